// file: core/bfo_regs.vh
`ifndef BFO_REGS_VH
`define BFO_REGS_VH

// ----------------------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------------------
`define BFO_FLAG_C 3'd0
`define BFO_FLAG_Z 3'd1
`define BFO_FLAG_N 3'd2
`define BFO_FLAG_V 3'd3
`define BFO_FLAG_S 3'd4
`define BFO_FLAG_H 3'd5
`define BFO_FLAG_T 3'd6
`define BFO_FLAG_I 3'd7

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define BFO_OP_NOP          4'h0
`define BFO_OP_FORCE_HIGH   4'h1
`define BFO_OP_FORCE_LOW    4'h2
`define BFO_OP_REG_TO_T     4'h3
`define BFO_OP_T_TO_REG     4'h4
`define BFO_OP_SWAP         4'h5
`define BFO_OP_SLEEP        4'h6
`define BFO_OP_WDOG_RESTART 4'h7
`define BFO_OP_OVF_RAISE    4'h8
`define BFO_OP_OVF_DROP     4'h9
`define BFO_OP_HALF_RAISE   4'ha
`define BFO_OP_HALF_DROP    4'hb
`define BFO_OP_SIGN_RAISE   4'hc
`define BFO_OP_SIGN_DROP    4'hd

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BFO_FLAGS_RESET 8'h00
`define BFO_DATA_RESET  8'h00

`endif

// file: core/bfo_unit.v
// What this block does
// - Bit-to-transfer copies source bit b into T, only T changes, one cycle.
// - Transfer-to-bit writes T into destination bit b, flags unchanged, one cycle.
// - Overflow raise sets V to one only, one cycle.
// - Overflow drop clears V to zero only, one cycle.
// - Half-carry raise sets H to one only, one cycle.
// - Half-carry drop clears H to zero only, one cycle.
// - Signed-test raise sets S to one only, one cycle.
// - Signed-test drop clears S to zero only, one cycle.
// - Sleep issues in one cycle, flags unchanged, sleep request pulsed.
// - Watchdog restart issues in one cycle, flags unchanged, restart pulsed.
`default_nettype none
`include "bfo_regs.vh"

module bfo_unit (
    input  wire       clk,
    input  wire       rst,
    input  wire       op_valid,
    input  wire [3:0] op_code,
    input  wire [2:0] op_sel,
    input  wire [7:0] reg_in,
    input  wire       flags_load,
    input  wire [7:0] flags_load_value,
    output reg  [7:0] core_flag_register,
    output reg  [7:0] reg_out,
    output reg        reg_write,
    output reg        sleep_req,
    output reg        watchdog_restart,
    output reg        op_done
);

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
    // One-hot mask for a bit position, used for flags and register bits.
    function [7:0] bit_mask;
        input [2:0] pos;
        begin
            bit_mask = 8'h01 << pos;
        end
    endfunction

    // Returns the word with one bit replaced by the given value.
    function [7:0] put_bit;
        input [7:0] word;
        input [2:0] pos;
        input       val;
        begin
            put_bit = val ? (word | bit_mask(pos)) : (word & ~bit_mask(pos));
        end
    endfunction

    // True when a valid instruction carries the wanted operation code.
    function op_is;
        input       valid;
        input [3:0] code;
        input [3:0] want;
        begin
            op_is = valid && (code == want);
        end
    endfunction

// ----------------------------------------------------------------------------
// Operation decode
// ----------------------------------------------------------------------------
    // Flag instructions.
    wire do_force_high = op_is(op_valid, op_code, `BFO_OP_FORCE_HIGH);
    wire do_force_low  = op_is(op_valid, op_code, `BFO_OP_FORCE_LOW);
    wire do_reg_to_t   = op_is(op_valid, op_code, `BFO_OP_REG_TO_T);
    wire do_ovf_raise  = op_is(op_valid, op_code, `BFO_OP_OVF_RAISE);
    wire do_ovf_drop   = op_is(op_valid, op_code, `BFO_OP_OVF_DROP);
    wire do_half_raise = op_is(op_valid, op_code, `BFO_OP_HALF_RAISE);
    wire do_half_drop  = op_is(op_valid, op_code, `BFO_OP_HALF_DROP);
    wire do_sign_raise = op_is(op_valid, op_code, `BFO_OP_SIGN_RAISE);
    wire do_sign_drop  = op_is(op_valid, op_code, `BFO_OP_SIGN_DROP);

    // Register result instructions.
    wire do_t_to_reg   = op_is(op_valid, op_code, `BFO_OP_T_TO_REG);
    wire do_swap       = op_is(op_valid, op_code, `BFO_OP_SWAP);

    // Issue-only instructions; no-operation and the spare codes only pulse op_done.
    wire do_sleep      = op_is(op_valid, op_code, `BFO_OP_SLEEP);
    wire do_wdog       = op_is(op_valid, op_code, `BFO_OP_WDOG_RESTART);

// ----------------------------------------------------------------------------
// Flag write selection
// ----------------------------------------------------------------------------
    // Every flag instruction touches exactly one flag: a one-hot enable and its value.
    reg [7:0] flag_we;
    reg [7:0] flag_wv;

    always @* begin
        flag_we = 8'h00;
        flag_wv = 8'h00;

        if (do_force_high) begin
            flag_we = bit_mask(op_sel);
            flag_wv = 8'hff;
        end

        if (do_force_low) begin
            flag_we = bit_mask(op_sel);
            flag_wv = 8'h00;
        end

        if (do_reg_to_t) begin
            flag_we = bit_mask(`BFO_FLAG_T);
            flag_wv = {8{reg_in[op_sel]}};
        end

        if (do_ovf_raise) begin
            flag_we = bit_mask(`BFO_FLAG_V);
            flag_wv = 8'hff;
        end

        if (do_ovf_drop) begin
            flag_we = bit_mask(`BFO_FLAG_V);
            flag_wv = 8'h00;
        end

        if (do_half_raise) begin
            flag_we = bit_mask(`BFO_FLAG_H);
            flag_wv = 8'hff;
        end

        if (do_half_drop) begin
            flag_we = bit_mask(`BFO_FLAG_H);
            flag_wv = 8'h00;
        end

        if (do_sign_raise) begin
            flag_we = bit_mask(`BFO_FLAG_S);
            flag_wv = 8'hff;
        end

        if (do_sign_drop) begin
            flag_we = bit_mask(`BFO_FLAG_S);
            flag_wv = 8'h00;
        end
    end

// ----------------------------------------------------------------------------
// Flag next values
// ----------------------------------------------------------------------------
    // A flag instruction wins over a load from the rest of the core in the same cycle.
    wire       take_load = flags_load && (flag_we == 8'h00);
    wire [7:0] next_flags;

    // Each flag picks, in order: its instruction, the core's load (only when no flag instruction issues), its own value.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            assign next_flags[gi] = flag_we[gi] ? flag_wv[gi] :
                                    take_load   ? flags_load_value[gi] :
                                                  core_flag_register[gi];
        end
    endgenerate

// ----------------------------------------------------------------------------
// Register result and pulses
// ----------------------------------------------------------------------------
    reg  [7:0] next_reg_out;
    reg        next_reg_write;
    wire       next_sleep = do_sleep;
    wire       next_wdog  = do_wdog;
    wire       next_done  = op_valid;

    // The result holds its last value; only reg_write marks a new one.
    always @* begin
        next_reg_out   = reg_out;
        next_reg_write = 1'b0;

        if (do_t_to_reg) begin
            next_reg_out   = put_bit(reg_in, op_sel, core_flag_register[`BFO_FLAG_T]);
            next_reg_write = 1'b1;
        end

        if (do_swap) begin
            next_reg_out   = {reg_in[3:0], reg_in[7:4]};
            next_reg_write = 1'b1;
        end
    end

// ----------------------------------------------------------------------------
// Status flags register
// ----------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            core_flag_register <= `BFO_FLAGS_RESET;
        end else begin
            core_flag_register <= next_flags;
        end
    end

// ----------------------------------------------------------------------------
// Register result
// ----------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_out   <= `BFO_DATA_RESET;
            reg_write <= 1'b0;
        end else begin
            reg_out   <= next_reg_out;
            reg_write <= next_reg_write;
        end
    end

// ----------------------------------------------------------------------------
// Issue pulses
// ----------------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_req        <= 1'b0;
            watchdog_restart <= 1'b0;
            op_done          <= 1'b0;
        end else begin
            sleep_req        <= next_sleep;
            watchdog_restart <= next_wdog;
            op_done          <= next_done;
        end
    end

endmodule // bfo_unit
`default_nettype wire

// file: sim/bfo_checker.sv
`default_nettype none
module bfo_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_sel,
    input wire logic [7:0] reg_in,
    input wire logic       flags_load,
    input wire logic [7:0] flags_load_value,
    input wire logic [7:0] core_flag_register,
    input wire logic [7:0] reg_out,
    input wire logic       reg_write,
    input wire logic       sleep_req,
    input wire logic       watchdog_restart,
    input wire logic       op_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ef;
    logic [7:0] er;
    always_comb begin
        ef = core_flag_register;
        er = (op_code == 4'h4) ? reg_in : {reg_in[3:0], reg_in[7:4]};
        case (op_code)
            4'h1: ef[op_sel] = 1'b1;
            4'h2: ef[op_sel] = 1'b0;
            4'h3: ef[6] = reg_in[op_sel];
            4'h4: er[op_sel] = core_flag_register[6];
            4'h8: ef[3] = 1'b1;
            4'h9: ef[3] = 1'b0;
            4'ha: ef[5] = 1'b1;
            4'hb: ef[5] = 1'b0;
            4'hc: ef[4] = 1'b1;
            4'hd: ef[4] = 1'b0;
            default: ;
        endcase
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_op(logic [3:0] c);
        op_valid && op_code == c;
    endsequence
    bit_copy_a:
        assert property (s_op(4'h3) |=> core_flag_register == $past(ef)) else $error("T copy");
    ovf_flag_a:
        assert property (s_op(4'h8) or s_op(4'h9) |=> core_flag_register == $past(ef)) else $error("V");
    half_flag_a:
        assert property (s_op(4'ha) or s_op(4'hb) |=> core_flag_register == $past(ef)) else $error("H");
    sign_flag_a:
        assert property (s_op(4'hc) or s_op(4'hd) |=> core_flag_register == $past(ef)) else $error("S");
    gen_flag_a:
        assert property (s_op(4'h1) or s_op(4'h2) |=> core_flag_register == $past(ef)) else $error("set");
    flags_hold_a:
        assert property (op_valid && !flags_load && op_code inside {0, 4, 5, 6, 7, 14, 15}
            |=> $stable(core_flag_register))
            else $error("flags moved");
    reg_result_a:
        assert property (s_op(4'h4) or s_op(4'h5) |=> reg_write && reg_out == $past(er)) else $error("reg");
    sleep_pulse_a:
        assert property (s_op(4'h6) |=> sleep_req) else $error("sleep");
    wdog_pulse_a:
        assert property (s_op(4'h7) |=> watchdog_restart) else $error("wdog");
    flags_load_a:
        assert property (flags_load && !(op_valid && op_code inside {1, 2, 3, 8, 9, 10, 11, 12, 13})
            |=> core_flag_register == $past(flags_load_value)) else $error("flag load");
    write_pulse_a:
        assert property (reg_write == $past(op_valid && op_code inside {4, 5}))
            else $error("write pulse");
    sleep_only_a:
        assert property (sleep_req == $past(op_valid && op_code == 4'h6))
            else $error("sleep pulse");
    wdog_only_a:
        assert property (watchdog_restart == $past(op_valid && op_code == 4'h7))
            else $error("wdog pulse");
    done_pulse_a:
        assert property (op_done == $past(op_valid)) else $error("done pulse");
endmodule // bfo_checker
`default_nettype wire

// file: sim/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       op_valid = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic [2:0] op_sel = 3'h0;
    logic [7:0] reg_in = 8'h00;
    logic       flags_load = 1'b0;
    logic [7:0] flags_load_value = 8'h00;
    wire logic [7:0] flags;
    wire logic [7:0] reg_out;
    wire logic  reg_write, sleep_req, watchdog_restart, op_done;
    int         n_mismatch = 0;
    int         num_checks = 0;
    always #4 clk = ~clk;
    bfo_unit dut_u (.clk, .rst, .op_valid, .op_code, .op_sel, .reg_in, .flags_load,
        .flags_load_value, .core_flag_register(flags), .reg_out, .reg_write,
        .sleep_req, .watchdog_restart, .op_done);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task op(input logic [3:0] c, input logic [2:0] s, input logic [7:0] r);
        {op_valid, op_code, op_sel, reg_in} = {1'b1, c, s, r};
        @(negedge clk);
        chk({7'h0, op_done}, 8'h01);
    endtask
    task t_flags;
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < 16; i++) begin
            op((i < 8) ? 4'h1 : 4'h2, i[2:0], 8'h00);
            e[i[2:0]] = (i < 8);
            chk(flags, e);
        end
        for (int k = 0; k < 6; k++) begin
            op(4'h8 + k[3:0], 3'h0, 8'h00);
            e[(k < 2) ? 3 : (k < 4) ? 5 : 4] = ~k[0];
            chk(flags, e);
        end
    endtask
    task t_bit;
        op(4'h3, 3'h2, 8'h04);
        chk(flags, 8'h40);
        op(4'h4, 3'h0, 8'h00);
        chk(reg_out, 8'h01);
        op(4'h3, 3'h7, 8'h7f);
        chk(flags, 8'h00);
        op(4'h4, 3'h7, 8'hff);
        chk(reg_out, 8'h7f);
    endtask
    task t_misc;
        op(4'h1, 3'h6, 8'h00);
        op(4'h5, 3'h0, 8'h3c);
        chk(reg_out, 8'hc3);
        chk({7'h0, reg_write}, 8'h01);
        op(4'h6, 3'h0, 8'h00);
        chk({7'h0, sleep_req, reg_write}, 8'h02);
        op(4'h7, 3'h0, 8'h00);
        chk({6'h0, watchdog_restart, sleep_req}, 8'h02);
        op(4'h0, 3'h0, 8'h00);
        chk(flags, 8'h40);
        op_valid = 1'b0;
        @(negedge clk);
        chk({7'h0, op_done}, 8'h00);
    endtask
    task t_load;
        {flags_load, flags_load_value} = {1'b1, 8'ha5};
        @(negedge clk);
        chk(flags, 8'ha5);
        op(4'h2, 3'h0, 8'h00);
        chk(flags, 8'ha4);
        flags_load = 1'b0;
        op(4'he, 3'h0, 8'h00);
        chk(flags, 8'ha4);
        chk({7'h0, reg_write}, 8'h00);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_flags();
        t_bit();
        t_misc();
        t_load();
        summarize();
    end
    initial begin
        #5000;
        n_mismatch++;
        summarize();
    end
endmodule // tb_top
bind bfo_unit bfo_checker chk_u (.clk, .rst, .op_valid, .op_code, .op_sel, .reg_in,
    .flags_load, .flags_load_value,
    .core_flag_register, .reg_out, .reg_write, .sleep_req, .watchdog_restart, .op_done);
`default_nettype wire
